// *** rtl/mesm_map.svh ***
// Register map, field positions and reset values of the event status and mask block.
`ifndef MESM_MAP_SVH
`define MESM_MAP_SVH

// ****************************************************************
// Register indices and byte address width
// ****************************************************************
`define MESM_IDX_STATUS_LOW 16'hE502
`define MESM_IDX_STATUS_HIGH 16'hE503
`define MESM_IDX_ENABLE_LOW 16'hE50A
`define MESM_IDX_ENABLE_HIGH 16'hE50B
`define MESM_IDX_SIGN_SELECT 16'hE701
`define MESM_ADDR_W 18

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define MESM_BIT_REACT_SEL 7
`define MESM_BIT_ACT_SEL 6
`define MESM_BIT_RESET_DONE 15
`define MESM_VALID_LOW 32'h0002_1DEF
`define MESM_VALID_HIGH 32'h0187_F3CB
`define MESM_FIXED_ONE_HIGH 32'h0020_0000
`define MESM_RST_STATUS_LOW 32'h0000_0000
`define MESM_RST_STATUS_HIGH 32'h0000_8000
`define MESM_RST_ENABLE 32'h0000_0000

`endif

// *** rtl/mesm_pkg.sv ***
// Types shared by the event status and mask block.
package mesm_pkg;

  // ****************************************************************
  // Event pulses from the metering core
  // ****************************************************************
  typedef struct packed {
    logic waveform_sample_flag;
    logic [2:0] react_flip_abc;
    logic [2:0] react_flip_def;
    logic [2:0] act_flip_abc;
    logic [2:0] act_flip_def;
    logic line_cycle_done_flag;
    logic reactive_half_full_grp1;
    logic reactive_half_full_grp2;
    logic active_half_full_grp1;
    logic active_half_full_grp2;
    logic voltage_peak_done;
    logic current_peak_done;
    logic high_voltage_flag;
    logic high_current_flag;
    logic voltage_sag_flag;
    logic reset_complete_flag;
    logic [2:0] current_zero_cross;
    logic volt_zero_cross_flag;
    logic [2:0] current_cross_timeout;
    logic volt_cross_timeout;
    logic no_power_grp1;
    logic no_power_grp2;
  } mesm_evt_s;

  // ****************************************************************
  // APB request
  // ****************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } mesm_apb_s;

endpackage

// *** rtl/mesm_top.sv ***
// Event status, mask and interrupt logic of the metering device, with an APB slave.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "mesm_map.svh"

module mesm_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire mesm_pkg::mesm_apb_s apb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Event pulses from the metering core
  input wire mesm_pkg::mesm_evt_s evt,
  // Interrupt outputs
  output logic irq_low_n,
  output logic irq_high_n
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic hit(input logic [17:0] addr, input logic [15:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  logic [31:0] st_low;
  logic [31:0] st_high;
  logic [31:0] en_low;
  logic [31:0] en_high;
  logic [1:0] sign_sel;

  wire setup = apb.psel & ~apb.penable;
  wire done = apb.psel & apb.penable & pready;
  wire wr = done & apb.pwrite;
  wire hit_sl = hit(apb.paddr, `MESM_IDX_STATUS_LOW);
  wire hit_sh = hit(apb.paddr, `MESM_IDX_STATUS_HIGH);
  wire hit_el = hit(apb.paddr, `MESM_IDX_ENABLE_LOW);
  wire hit_eh = hit(apb.paddr, `MESM_IDX_ENABLE_HIGH);
  wire hit_ss = hit(apb.paddr, `MESM_IDX_SIGN_SELECT);
  wire mapped = hit_sl | hit_sh | hit_el | hit_eh | hit_ss;

  // ****************************************************************
  // Channel group selection for power sign changes
  // ****************************************************************
  wire react_sel = sign_sel[1];
  wire act_sel = sign_sel[0];
  wire [2:0] react_flip = react_sel ? evt.react_flip_def : evt.react_flip_abc;
  wire [2:0] act_flip = act_sel ? evt.act_flip_def : evt.act_flip_abc;

  // ****************************************************************
  // Event set vectors
  // ****************************************************************
  logic [31:0] set_low;
  logic [31:0] set_high;

  always_comb begin
    set_low = 32'h0000_0000;
    set_low[17] = evt.waveform_sample_flag;
    set_low[12:10] = react_flip;
    set_low[8:6] = act_flip;
    set_low[5] = evt.line_cycle_done_flag;
    set_low[2] = evt.reactive_half_full_grp1;
    set_low[3] = evt.reactive_half_full_grp2;
    set_low[1] = evt.active_half_full_grp2;
    set_low[0] = evt.active_half_full_grp1;
  end

  always_comb begin
    set_high = 32'h0000_0000;
    set_high[24] = evt.voltage_peak_done;
    set_high[23] = evt.current_peak_done;
    set_high[18] = evt.high_voltage_flag;
    set_high[17] = evt.high_current_flag;
    set_high[16] = evt.voltage_sag_flag;
    set_high[15] = evt.reset_complete_flag;
    set_high[14:12] = evt.current_zero_cross;
    set_high[9] = evt.volt_zero_cross_flag;
    set_high[8:6] = evt.current_cross_timeout;
    set_high[3] = evt.volt_cross_timeout;
    set_high[1] = evt.no_power_grp2;
    set_high[0] = evt.no_power_grp1;
  end

  // ****************************************************************
  // Next values
  // ****************************************************************
  // A set in the same cycle as a clear wins, so no event is lost.
  wire [31:0] clr_low = (wr & hit_sl) ? apb.pwdata : 32'h0000_0000;
  wire [31:0] clr_high = (wr & hit_sh) ? apb.pwdata : 32'h0000_0000;
  wire [31:0] next_st_low = ((st_low & ~clr_low) | set_low) & `MESM_VALID_LOW;
  wire [31:0] next_st_high = ((st_high & ~clr_high) | set_high) & `MESM_VALID_HIGH;
  wire [31:0] next_en_low = (wr & hit_el) ? (apb.pwdata & `MESM_VALID_LOW) : en_low;
  wire [31:0] next_en_high = (wr & hit_eh) ? (apb.pwdata & `MESM_VALID_HIGH) : en_high;
  wire [1:0] next_sign_sel = (wr & hit_ss) ?
    {apb.pwdata[`MESM_BIT_REACT_SEL], apb.pwdata[`MESM_BIT_ACT_SEL]} : sign_sel;
  wire next_irq_low_n = ~|(next_st_low & next_en_low);
  wire next_irq_high_n = ~|(next_st_high & next_en_high);

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Reserved high bit 21 is not a flag and always reads one.
  wire [31:0] vis_high = st_high | `MESM_FIXED_ONE_HIGH;
  wire [31:0] sel_word = {24'h00_0000, sign_sel[1], sign_sel[0], 6'h00};
  wire [31:0] rd_data = hit_sl ? st_low :
                        hit_sh ? vis_high :
                        hit_el ? en_low :
                        hit_eh ? en_high :
                        hit_ss ? sel_word : 32'h0000_0000;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_low <= `MESM_RST_STATUS_LOW;
      st_high <= `MESM_RST_STATUS_HIGH;
      en_low <= `MESM_RST_ENABLE;
      en_high <= `MESM_RST_ENABLE;
      sign_sel <= 2'h0;
    end else begin
      st_low <= next_st_low;
      st_high <= next_st_high;
      en_low <= next_en_low;
      en_high <= next_en_high;
      sign_sel <= next_sign_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_low_n <= 1'b1;
      irq_high_n <= 1'b1;
    end else begin
      irq_low_n <= next_irq_low_n;
      irq_high_n <= next_irq_high_n;
    end
  end

  // The answer is prepared at the setup edge, so every access takes two cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~apb.pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_clear_low(int b);
    wr && hit_sl && apb.pwdata[b];
  endsequence

  sequence s_no_clear_low(int b);
    !(wr && hit_sl && apb.pwdata[b]);
  endsequence

  sequence s_write_enable_low;
    wr && hit_el;
  endsequence

  sequence s_write_enable_high;
    wr && hit_eh;
  endsequence

  a_wave_flag_set:
    assert property (evt.waveform_sample_flag |=> st_low[17])
    else $error("Waveform ready flag not set.");

  a_react_flip_sel:
    assert property (!react_sel && evt.react_flip_abc[1] |=> st_low[11])
    else $error("Reactive sign flag of second channel not set.");

  a_act_flip_group:
    assert property (act_sel && evt.act_flip_def[2] |=> st_low[8])
    else $error("Active sign flag of third channel not set.");

  a_line_half_full:
    assert property (evt.line_cycle_done_flag && evt.reactive_half_full_grp1
                     |=> st_low[5] && st_low[2])
    else $error("Line cycle or reactive half full flag not set.");

  a_active_half:
    assert property (evt.active_half_full_grp2
                     |=> st_low[1] ##0 (s_clear_low(1) or (1'b1 ##1 st_low[1])))
    else $error("Active half full flag lost.");

  a_peak_flags:
    assert property (evt.voltage_peak_done || evt.current_peak_done
                     |=> st_high[24] || st_high[23])
    else $error("Peak period flag not set.");

  a_fault_flags:
    assert property (evt.high_voltage_flag && evt.high_current_flag && evt.voltage_sag_flag
                     |=> st_high[18:16] == 3'h7)
    else $error("Voltage or current fault flag not set.");

  a_reset_flag:
    assert property (evt.reset_complete_flag |=> vis_high[`MESM_BIT_RESET_DONE])
    else $error("Reset complete flag not set.");

  a_zero_cross:
    assert property (evt.current_zero_cross == 3'h7 |=> st_high[14:12] == 3'h7)
    else $error("Current zero crossing flags not set.");

  a_timeout_noload:
    assert property (evt.current_cross_timeout[0] && evt.no_power_grp1
                     |=> st_high[6] && st_high[0])
    else $error("Timeout or no-load flag not set.");

  a_reserved_read:
    assert property (setup && hit_sh && !apb.pwrite |=> prdata[21] &&
                     (prdata & ~`MESM_VALID_HIGH & ~`MESM_FIXED_ONE_HIGH) == 32'h0000_0000)
    else $error("Reserved high bits read wrong.");

  a_mask_low:
    assert property (s_write_enable_low |=> en_low == ($past(apb.pwdata) & `MESM_VALID_LOW))
    else $error("Low enable register not loaded.");

  a_mask_high:
    assert property (s_write_enable_high |=> en_high == ($past(apb.pwdata) & `MESM_VALID_HIGH))
    else $error("High enable register not loaded.");

  a_irq_follows:
    assert property (irq_low_n == !(|(st_low & en_low)) && irq_high_n == !(|(st_high & en_high)))
    else $error("Interrupt output disagrees with flags.");

  a_flag_clear:
    assert property (s_clear_low(17) ##0 !evt.waveform_sample_flag |=> !st_low[17])
    else $error("Write of one did not clear flag.");

  a_flag_hold:
    assert property (st_low[17] ##0 s_no_clear_low(17) |=> st_low[17])
    else $error("Flag dropped without a clear.");

  a_react_flip_def:
    assert property (react_sel && evt.react_flip_def[0] |=> st_low[10])
    else $error("Reactive sign flag of first channel not set.");

  a_react_flip_third:
    assert property (!react_sel && evt.react_flip_abc[2] |=> st_low[12])
    else $error("Reactive sign flag of third channel not set.");

  a_act_flip_first:
    assert property (!act_sel && evt.act_flip_abc[0] |=> st_low[6])
    else $error("Active sign flag of first channel not set.");

  a_act_flip_mid:
    assert property (act_sel && evt.act_flip_def[1] |=> st_low[7])
    else $error("Active sign flag of second channel not set.");

  a_react_half_one:
    assert property (evt.reactive_half_full_grp1 |=> st_low[2])
    else $error("Reactive half full flag not set.");

  a_react_half_two:
    assert property (evt.reactive_half_full_grp2 |=> st_low[3])
    else $error("Second group half full flag not set.");

  a_active_half_one:
    assert property (evt.active_half_full_grp1 |=> st_low[0])
    else $error("First group active half full flag not set.");

  a_volt_peak:
    assert property (evt.voltage_peak_done |=> st_high[24])
    else $error("Voltage peak flag not set.");

  a_curr_peak:
    assert property (evt.current_peak_done |=> st_high[23])
    else $error("Current peak flag not set.");

  a_over_volt:
    assert property (evt.high_voltage_flag |=> st_high[18])
    else $error("Overvoltage flag not set.");

  a_over_curr:
    assert property (evt.high_current_flag |=> st_high[17])
    else $error("Overcurrent flag not set.");

  a_sag_flag:
    assert property (evt.voltage_sag_flag |=> st_high[16])
    else $error("Sag flag not set.");

  a_volt_cross:
    assert property (evt.volt_zero_cross_flag |=> st_high[9])
    else $error("Voltage zero crossing flag not set.");

  a_curr_timeout:
    assert property (evt.current_cross_timeout == 3'h7 |=> st_high[8:6] == 3'h7)
    else $error("Current crossing timeout flags not set.");

  a_volt_timeout:
    assert property (evt.volt_cross_timeout |=> st_high[3])
    else $error("Voltage crossing timeout flag not set.");

  a_noload_two:
    assert property (evt.no_power_grp2 |=> st_high[1])
    else $error("Second group no-load flag not set.");

  a_sign_select:
    assert property (wr && hit_ss |=> sign_sel == {$past(apb.pwdata[`MESM_BIT_REACT_SEL]),
                                                   $past(apb.pwdata[`MESM_BIT_ACT_SEL])})
    else $error("Sign group select not loaded.");

  a_ignored_flip:
    assert property (!react_sel && evt.react_flip_def[1] && !evt.react_flip_abc[1] &&
                     !st_low[11] |=> !st_low[11])
    else $error("Unselected group set a sign flag.");

  a_irq_high_set:
    assert property (st_high[18] && en_high[18] |-> !irq_high_n)
    else $error("Enabled flag did not raise the interrupt.");

  a_high_clear:
    assert property (wr && hit_sh && apb.pwdata[16] && !evt.voltage_sag_flag |=> !st_high[16])
    else $error("Write of one did not clear high flag.");

  a_high_hold:
    assert property (st_high[16] && !(wr && hit_sh && apb.pwdata[16]) |=> st_high[16])
    else $error("High flag dropped without a clear.");

  a_unmapped_err:
    assert property (setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped access not refused.");

  a_mapped_ok:
    assert property (setup && mapped |=> !pslverr)
    else $error("Mapped access refused.");

  a_write_rdata:
    assert property (setup && apb.pwrite |=> prdata == 32'h0000_0000)
    else $error("Read data not zero on a write.");

  a_apb_answer:
    assert property (setup |=> pready ##1 !pready)
    else $error("APB answer timing wrong.");

endmodule
`default_nettype wire

// *** sim/mesm_host.sv ***
// Host model: an APB master that runs one transfer per request pulse.
`timescale 1ns/10ps
`default_nettype none
module mesm_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request side
  input wire logic go,
  input wire logic wr,
  input wire logic [17:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  // APB master
  output mesm_pkg::mesm_apb_s apb,
  input wire logic pready
);
  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // Released address and data show their inverse, so a stale value never passes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (apb.penable && pready) begin
        apb <= '{1'b0, 1'b0, apb.pwrite, ~apb.paddr, ~apb.pwdata};
        done <= 1'b1;
      end else if (apb.psel) begin
        apb.penable <= 1'b1;
      end else if (go) begin
        apb <= '{1'b1, 1'b0, wr, addr, wdata};
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/meter_event_status_mask_tb.sv ***
// Self-checking testbench of the event status and mask block.
`timescale 1ns/10ps
`default_nettype none
`include "mesm_map.svh"
module meter_event_status_mask_tb;
  logic pclk, presetn, pready, pslverr, irq_low_n, irq_high_n, go, wr, done, rsel, asel;
  logic [31:0] prdata, wdata, st_lo, st_hi, en_lo, en_hi, seed;
  logic [17:0] addr;
  logic [33:0] v;
  logic [34:0] exq[$];
  mesm_pkg::mesm_apb_s apb;
  mesm_pkg::mesm_evt_s evt;
  int num_errors, total_checks;
  localparam logic [17:0] A_SL = {`MESM_IDX_STATUS_LOW, 2'b00};
  localparam logic [17:0] A_SH = {`MESM_IDX_STATUS_HIGH, 2'b00};
  localparam logic [17:0] A_EL = {`MESM_IDX_ENABLE_LOW, 2'b00};
  localparam logic [17:0] A_EH = {`MESM_IDX_ENABLE_HIGH, 2'b00};
  localparam logic [17:0] A_SS = {`MESM_IDX_SIGN_SELECT, 2'b00};
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;

  mesm_top i_dut (.pclk(pclk), .presetn(presetn), .apb(apb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .evt(evt), .irq_low_n(irq_low_n),
    .irq_high_n(irq_high_n));
  mesm_host i_host (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .done(done), .apb(apb), .pready(pready));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [63:0] emap(input mesm_pkg::mesm_evt_s e);
    logic [31:0] l, h;
    l = '0;
    h = '0;
    l[17] = e.waveform_sample_flag;
    l[12:10] = rsel ? e.react_flip_def : e.react_flip_abc;
    l[8:5] = {asel ? e.act_flip_def : e.act_flip_abc, e.line_cycle_done_flag};
    l[3:0] = {e.reactive_half_full_grp2, e.reactive_half_full_grp1,
      e.active_half_full_grp2, e.active_half_full_grp1};
    h[24:23] = {e.voltage_peak_done, e.current_peak_done};
    h[18:15] = {e.high_voltage_flag, e.high_current_flag, e.voltage_sag_flag,
      e.reset_complete_flag};
    h[14:12] = e.current_zero_cross;
    h[9:6] = {e.volt_zero_cross_flag, e.current_cross_timeout};
    h[3] = e.volt_cross_timeout;
    h[1:0] = {e.no_power_grp2, e.no_power_grp1};
    return {h, l};
  endfunction

  task chk(input logic [34:0] s, input logic [34:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Expected irq levels are noted at request time; no event arrives during a transfer.
  task apb_op(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    logic bad;
    bad = !(a inside {A_SL, A_SH, A_EL, A_EH, A_SS});
    exq.push_back({~|(st_lo & en_lo), ~|(st_hi & en_hi), bad, (w | bad) ? 32'h0000_0000 : e});
    @(posedge pclk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (n == 20) num_errors++;
    if (w && !bad) begin
      case (a)
        A_SL: st_lo = st_lo & ~d;
        A_SH: st_hi = (st_hi & ~d) | `MESM_FIXED_ONE_HIGH;
        A_EL: en_lo = d & `MESM_VALID_LOW;
        A_EH: en_hi = d & `MESM_VALID_HIGH;
        default: {rsel, asel} = d[7:6];
      endcase
    end
  endtask

  task fire(input logic [33:0] x);
    logic [63:0] m;
    m = emap(mesm_pkg::mesm_evt_s'(x));
    @(posedge pclk);
    evt <= mesm_pkg::mesm_evt_s'(x);
    @(posedge pclk);
    evt <= '0;
    st_lo = st_lo | m[31:0];
    st_hi = st_hi | m[63:32];
  endtask

  task rd2;
    apb_op(1'b0, A_SL, 32'h0000_0000, st_lo);
    apb_op(1'b0, A_SH, 32'h0000_0000, st_hi);
  endtask

  // ****************************************************************
  // Clock, monitor, watchdog and main sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (apb.psel && apb.penable && pready === 1'b1) begin
      if (exq.size() == 0) num_errors++;
      else chk({irq_low_n, irq_high_n, pslverr, prdata}, exq.pop_front());
    end
  end

  initial begin
    #300_000;
    num_errors++;
    give_verdict;
  end

  initial begin
    presetn = 1'b0;
    evt = '0;
    {go, wr, addr, wdata, rsel, asel, num_errors, total_checks} = '0;
    {st_lo, en_lo, en_hi} = '0;
    st_hi = `MESM_RST_STATUS_HIGH | `MESM_FIXED_ONE_HIGH;
    seed = 32'h0001_2D95;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd2;
    apb_op(1'b0, A_EL, 32'h0000_0000, 32'h0000_0000);
    apb_op(1'b0, A_SS, 32'h0000_0000, 32'h0000_0000);
    apb_op(1'b1, 18'h0_0100, ONES, 32'h0000_0000);
    apb_op(1'b0, 18'h0_0100, 32'h0000_0000, 32'h0000_0000);
    apb_op(1'b1, A_EL, ONES, 32'h0000_0000);
    apb_op(1'b1, A_EH, ONES, 32'h0000_0000);
    apb_op(1'b0, A_EL, 32'h0000_0000, `MESM_VALID_LOW);
    apb_op(1'b0, A_EH, 32'h0000_0000, `MESM_VALID_HIGH);
    for (int j = 0; j < 2; j++) begin
      apb_op(1'b1, A_SS, j ? 32'h0000_00C0 : 32'h0000_0000, 32'h0000_0000);
      for (int i = 0; i < 34; i++) begin
        fire(34'h0_0000_0001 << i);
        rd2;
        apb_op(1'b1, A_SL, ONES, 32'h0000_0000);
        apb_op(1'b1, A_SH, ONES, 32'h0000_0000);
      end
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {st_lo, en_lo, en_hi, rsel, asel} = '0;
    st_hi = `MESM_RST_STATUS_HIGH | `MESM_FIXED_ONE_HIGH;
    rd2;
    apb_op(1'b0, A_EH, 32'h0000_0000, 32'h0000_0000);
    apb_op(1'b0, A_SS, 32'h0000_0000, 32'h0000_0000);
    for (int k = 0; k < 40; k++) begin
      seed = xs(seed);
      apb_op(1'b1, A_SS, seed, 32'h0000_0000);
      seed = xs(seed);
      apb_op(1'b1, A_EL, seed, 32'h0000_0000);
      apb_op(1'b0, A_EL, 32'h0000_0000, seed & `MESM_VALID_LOW);
      seed = xs(seed);
      apb_op(1'b1, A_EH, seed, 32'h0000_0000);
      seed = xs(seed);
      v[31:0] = seed;
      seed = xs(seed);
      v[33:32] = seed[1:0];
      fire(v);
      rd2;
      apb_op(1'b1, A_SL, 32'h0000_0000, 32'h0000_0000);
      apb_op(1'b1, A_SL, seed, 32'h0000_0000);
      apb_op(1'b1, A_SH, seed, 32'h0000_0000);
      rd2;
    end
    give_verdict;
  end
endmodule
`default_nettype wire
